// [hw/icd_params.svh]
/*
  Constants of the ISA card configuration and decode block: bus offsets,
  reset values and timing counts. Assumes inclusion by bare name only.
*/
`ifndef ICD_PARAMS_SVH
`define ICD_PARAMS_SVH
// Overview of operation
// - window of 32 port addresses with FIFO enabled, 16 with it disabled; at base 3F0 hex the window is 16 either way.
// - base address selectable from 000 to 3F0 hex in steps of 16.
// - base address after reset is 300 hex.
// - base field bits 5..0 compare against ISA address lines A9..A4.
// - eight balanced channels by default, else sixteen single-ended channels.
// - DMA request on channel 1 or 3, channel 3 by default.
// - timer input clock 10 MHz or 1 MHz, 1 MHz by default.
// - pacer rate is timer clock over product of two cascaded divisors.
// - FIFO enabled: each result goes to offsets 0/1 and, unless the FIFO is full, into FIFO 23/24.
// - FIFO disabled: results only at offsets 0/1, no FIFO path.
// - FIFO half full raises one ISA line from 2 to 7, line 2 default.
// - register at offset 6 enables or disables the half-full interrupt.
// - converter trigger from timer gate-zero source (default) or input two.
// - counter 0 gate from connector gate pin (default) or input zero.
// - output bits 0..3 each routed to ribbon (default) or main connector.
// - output converter code 0..4095 taken as a 12-bit value.

// ------------------------------------------------------------
// wishbone byte offsets
// ------------------------------------------------------------
`define ICD_WB_CFG 6'h00
`define ICD_WB_FIRST_PACER_DIVISOR 6'h04
`define ICD_WB_SECOND_PACER_DIVISOR 6'h08
`define ICD_WB_STAT 6'h0C
`define ICD_WB_CLR 6'h10
`define ICD_WB_IEN 6'h14
`define ICD_WB_STATE 6'h18
// cfg reset: base 30h (port 300h), fifo on, balanced, dma ch3, 1 MHz, irq 2
`define ICD_CFG_RST 20'h021F0
`define ICD_BASE_RST 6'h30
// ------------------------------------------------------------
// isa port offsets from base
// ------------------------------------------------------------
`define ICD_OFF_RES_LO 5'h00
`define ICD_OFF_RES_HI 5'h01
`define ICD_OFF_CHAN 5'h02
`define ICD_OFF_DO_LO 5'h03
`define ICD_OFF_DA_LO 5'h04
`define ICD_OFF_DA_HI 5'h05
`define ICD_OFF_FIRQ 5'h06
`define ICD_OFF_DO_HI 5'h0B
`define ICD_OFF_FIFO_LO 5'h17
`define ICD_OFF_FIFO_HI 5'h18
// status bit positions
`define ICD_EV_HALF 0
`define ICD_EV_OVF 1
`define ICD_EV_PACER 2
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define ICD_CLK_MHZ 50
`define ICD_TCLK_SLOW_MHZ 1
`define ICD_TCLK_FAST_MHZ 10
`define ICD_TCLK_SLOW_CYC (`ICD_CLK_MHZ / `ICD_TCLK_SLOW_MHZ)
`define ICD_TCLK_FAST_CYC (`ICD_CLK_MHZ / `ICD_TCLK_FAST_MHZ)
`endif

// [hw/icd_pkg.sv]
/*
  Types of the ISA card configuration and decode block.
  Assumes the constants header is included where offsets are needed.
*/
package icd_pkg;
  // configuration word, most significant field first
  typedef struct packed {
    logic dma_en;
    logic [3:0] route_main;
    logic [2:0] irq_line;
    logic gate_di0;
    logic trig_di2;
    logic clk10;
    logic dma_ch3;
    logic balanced;
    logic fifo_en;
    logic [5:0] base;
  } icd_cfg_t;
  // one isa bus request as sampled
  typedef struct packed {
    logic [9:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } icd_isa_req_t;
endpackage : icd_pkg

// [hw/icd_top.sv]
/*
  ISA card configuration, address decode, result FIFO, pacer and routing.
  Assumes ISA strobes and pins already synchronous to clk, and a classic
  Wishbone master for the configuration registers.
*/
// Design decisions made here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`include "icd_params.svh"
module icd_top
  import icd_pkg::*;
#(
  parameter int DEPTH = 16
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_irq_o,
  // isa bus
  input wire icd_isa_req_t isa_req,
  output logic [7:0] isa_data_out,
  output logic isa_data_oe,
  output logic card_sel,
  output logic [7:0] isa_irq,
  output logic [3:0] isa_drq,
  input wire logic [3:0] isa_dack,
  // converter and field pins
  input wire logic conv_valid,
  input wire logic [11:0] conv_data,
  input wire logic timer_gate_zero_source,
  input wire logic gate_pin,
  input wire logic [15:0] di,
  output logic [3:0] adc_chan,
  output logic conv_trig,
  output logic ctr0_gate,
  output logic pacer_out,
  output logic [11:0] da_code,
  output logic [15:0] ribbon_do,
  output logic [3:0] main_do
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] HALF = (AW+1)'(DEPTH / 2);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [5:0] SLOW_LIM = 6'(`ICD_TCLK_SLOW_CYC - 1);
  localparam logic [5:0] FAST_LIM = 6'(`ICD_TCLK_FAST_CYC - 1);

  logic [19:0] cfg_q;
  logic [15:0] first_pacer_divisor_q, second_pacer_divisor_q, c1_q, c2_q;
  logic [2:0] stat_q, ien_q;
  logic ack_q, irq_q, prev_rd_q, prev_wr_q, half_q, firq_en_q;
  logic [31:0] dat_q;
  logic [11:0] mem [DEPTH];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q;
  logic [11:0] result_q, da_q;
  logic [3:0] da_lo_q, chan_sel_q;
  logic [15:0] do_q;
  logic [5:0] tick_q;
  logic sel_q, oe_q, trig_q, gate_q, pacer_q;
  logic [7:0] rdata_q, isairq_q;
  logic [3:0] drq_q, chan_q, main_q;
  logic [15:0] ribbon_q;
  icd_cfg_t cfg;
  assign cfg = icd_cfg_t'(cfg_q);

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  // upper half of a 32-port window; top base has no block above it
  wire logic [5:0] base_nx = cfg.base + 6'h01;
  wire logic hit_lo = isa_req.addr[9:4] == cfg.base;
  wire logic hit_hi = cfg.fifo_en && cfg.base != 6'h3F
                      && isa_req.addr[9:4] == base_nx;
  wire logic hit = hit_lo | hit_hi;
  wire logic [4:0] off = {hit_hi, isa_req.addr[3:0]};
  wire logic rd_edge = ce && hit && isa_req.rd && !prev_rd_q;
  wire logic wr_edge = ce && hit && isa_req.wr && !prev_wr_q;

  // ------------------------------------------------------------
  // result fifo
  // ------------------------------------------------------------
  wire logic empty = cnt_q == '0;
  wire logic full = cnt_q == FULL;
  wire logic push = conv_valid && cfg.fifo_en && !full;
  wire logic ovf = conv_valid && cfg.fifo_en && full;
  wire logic pop = rd_edge && off == `ICD_OFF_FIFO_HI && cfg.fifo_en && !empty;
  wire logic half = cnt_q >= HALF;
  wire logic half_rise = half && !half_q;
  wire logic [11:0] head = mem[rp_q];
  // reads of the fifo ports give zero when the fifo is off
  wire logic [7:0] rd_mux =
    off == `ICD_OFF_RES_LO ? result_q[7:0] :
    off == `ICD_OFF_RES_HI ? {4'h0, result_q[11:8]} :
    off == `ICD_OFF_FIRQ ? {7'h00, firq_en_q} :
    off == `ICD_OFF_FIFO_LO && cfg.fifo_en ? head[7:0] :
    off == `ICD_OFF_FIFO_HI && cfg.fifo_en ? {4'h0, head[11:8]} : 8'h00;

  // ------------------------------------------------------------
  // pacer cascade
  // ------------------------------------------------------------
  wire logic [5:0] tick_lim = cfg.clk10 ? FAST_LIM : SLOW_LIM;
  wire logic tick = ce && tick_q == tick_lim;
  wire logic c1_wrap = tick && c1_q == 16'h0000;
  wire logic c2_wrap = c1_wrap && c2_q == 16'h0000;

  // ------------------------------------------------------------
  // wishbone decode
  // ------------------------------------------------------------
  wire logic wb_req = ce && wb_cyc_i && wb_stb_i && !ack_q;
  wire logic wb_wr = wb_req && wb_we_i;
  wire logic [31:0] bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                             {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire logic [31:0] cfg_w = ({12'h000, cfg_q} & ~bmask) | (wb_dat_i & bmask);
  wire logic [31:0] first_pacer_divisor_w = ({16'h0000, first_pacer_divisor_q} & ~bmask) | (wb_dat_i & bmask);
  wire logic [31:0] second_pacer_divisor_w = ({16'h0000, second_pacer_divisor_q} & ~bmask) | (wb_dat_i & bmask);
  wire logic wr_cfg = wb_wr && wb_adr_i == `ICD_WB_CFG;
  wire logic wr_div = wb_wr && (wb_adr_i == `ICD_WB_FIRST_PACER_DIVISOR || wb_adr_i == `ICD_WB_SECOND_PACER_DIVISOR);
  wire logic [2:0] clr = wb_wr && wb_adr_i == `ICD_WB_CLR ? wb_dat_i[2:0] & bmask[2:0] : 3'h0;
  wire logic [2:0] ev = {c2_wrap, ovf, half_rise};
  wire logic [2:0] stat_d = (stat_q & ~clr) | ev; // set beats clear
  wire logic [31:0] wb_rd =
    wb_adr_i == `ICD_WB_CFG ? {12'h000, cfg_q} :
    wb_adr_i == `ICD_WB_FIRST_PACER_DIVISOR ? {16'h0000, first_pacer_divisor_q} :
    wb_adr_i == `ICD_WB_SECOND_PACER_DIVISOR ? {16'h0000, second_pacer_divisor_q} :
    wb_adr_i == `ICD_WB_STAT ? {29'h0, stat_q} :
    wb_adr_i == `ICD_WB_IEN ? {29'h0, ien_q} :
    wb_adr_i == `ICD_WB_STATE ? {16'h0000, 7'h00, half_q, 3'h0, 5'(cnt_q)} : 32'h0;

  // wishbone registers; every address answers in one cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_q <= `ICD_CFG_RST;
      first_pacer_divisor_q <= 16'h0002;
      second_pacer_divisor_q <= 16'h0002;
      stat_q <= 3'h0;
      ien_q <= 3'h0;
      ack_q <= 1'b0;
      dat_q <= 32'h0;
      irq_q <= 1'b0;
    end else if (ce) begin
      ack_q <= wb_req;
      if (wb_req) dat_q <= wb_rd;
      if (wr_cfg) cfg_q <= cfg_w[19:0];
      if (wb_wr && wb_adr_i == `ICD_WB_FIRST_PACER_DIVISOR) first_pacer_divisor_q <= first_pacer_divisor_w[15:0];
      if (wb_wr && wb_adr_i == `ICD_WB_SECOND_PACER_DIVISOR) second_pacer_divisor_q <= second_pacer_divisor_w[15:0];
      if (wb_wr && wb_adr_i == `ICD_WB_IEN) ien_q <= wb_dat_i[2:0];
      stat_q <= stat_d;
      irq_q <= |(stat_q & ien_q);
    end
  end

  // fifo storage and pointers; disabling the fifo empties it
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      half_q <= 1'b0;
    end else if (ce) begin
      half_q <= half;
      if (!cfg.fifo_en) begin
        wp_q <= '0;
        rp_q <= '0;
        cnt_q <= '0;
      end else begin
        if (push) wp_q <= wp_q + 1'b1;
        if (pop) rp_q <= rp_q + 1'b1;
        cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
    end
  end

  // fifo array has no reset, only its pointers do
  always_ff @(posedge clk) begin
    if (ce && push) mem[wp_q] <= conv_data;
  end

  // host port writes and result latch
  always_ff @(posedge clk) begin
    if (rst) begin
      result_q <= 12'h000;
      chan_sel_q <= 4'h0;
      do_q <= 16'h0000;
      da_lo_q <= 4'h0;
      da_q <= 12'h000;
      firq_en_q <= 1'b0;
      prev_rd_q <= 1'b0;
      prev_wr_q <= 1'b0;
    end else if (ce) begin
      prev_rd_q <= isa_req.rd;
      prev_wr_q <= isa_req.wr;
      if (conv_valid) result_q <= conv_data;
      if (wr_edge) begin
        case (off)
          `ICD_OFF_CHAN: chan_sel_q <= isa_req.wdata[3:0];
          `ICD_OFF_DO_LO: do_q[7:0] <= isa_req.wdata;
          `ICD_OFF_DO_HI: do_q[15:8] <= isa_req.wdata;
          `ICD_OFF_DA_LO: da_lo_q <= isa_req.wdata[7:4];
          // code lands whole on the high write, so no glitch between bytes
          `ICD_OFF_DA_HI: da_q <= {isa_req.wdata, da_lo_q};
          `ICD_OFF_FIRQ: firq_en_q <= isa_req.wdata[0];
          default: ;
        endcase
      end
    end
  end

  // timer clock tick and the two cascaded counters
  always_ff @(posedge clk) begin
    if (rst || wr_div || wr_cfg) begin
      tick_q <= 6'h00;
      c1_q <= 16'h0000;
      c2_q <= 16'h0000;
    end else if (ce) begin
      tick_q <= tick ? 6'h00 : tick_q + 6'h01;
      if (tick) c1_q <= c1_wrap ? first_pacer_divisor_q - 16'h0001 : c1_q - 16'h0001;
      if (c1_wrap) c2_q <= c2_wrap ? second_pacer_divisor_q - 16'h0001 : c2_q - 16'h0001;
    end
  end

  // registered pins toward the isa bus and the field
  always_ff @(posedge clk) begin
    if (rst) begin
      sel_q <= 1'b0;
      oe_q <= 1'b0;
      rdata_q <= 8'h00;
      isairq_q <= 8'h00;
      drq_q <= 4'h0;
      chan_q <= 4'h0;
      trig_q <= 1'b0;
      gate_q <= 1'b0;
      pacer_q <= 1'b0;
      ribbon_q <= 16'h0000;
      main_q <= 4'h0;
    end else if (ce) begin
      sel_q <= hit;
      oe_q <= hit && isa_req.rd;
      if (hit && isa_req.rd) rdata_q <= rd_mux;
      // lines 0 and 1 are not reachable settings and stay quiet
      isairq_q <= half && firq_en_q && cfg.fifo_en && cfg.irq_line >= 3'd2
                  ? 8'h01 << cfg.irq_line : 8'h00;
      drq_q[1] <= (drq_q[1] && !isa_dack[1]) || (conv_valid && cfg.dma_en && !cfg.dma_ch3);
      drq_q[3] <= (drq_q[3] && !isa_dack[3]) || (conv_valid && cfg.dma_en && cfg.dma_ch3);
      drq_q[0] <= 1'b0;
      drq_q[2] <= 1'b0;
      // balanced mode keeps three select bits and forces the top bit low
      chan_q <= cfg.balanced ? {1'b0, chan_sel_q[2:0]} : chan_sel_q;
      trig_q <= cfg.trig_di2 ? di[2] : timer_gate_zero_source;
      gate_q <= cfg.gate_di0 ? di[0] : gate_pin;
      pacer_q <= c2_wrap;
      ribbon_q <= {do_q[15:4], do_q[3:0] & ~cfg.route_main};
      main_q <= do_q[3:0] & cfg.route_main;
    end
  end

  assign wb_dat_o = dat_q;
  assign wb_ack_o = ack_q;
  assign wb_irq_o = irq_q;
  assign isa_data_out = rdata_q;
  assign isa_data_oe = oe_q;
  assign card_sel = sel_q;
  assign isa_irq = isairq_q;
  assign isa_drq = drq_q;
  assign adc_chan = chan_q;
  assign conv_trig = trig_q;
  assign ctr0_gate = gate_q;
  assign pacer_out = pacer_q;
  assign da_code = da_q;
  assign ribbon_do = ribbon_q;
  assign main_do = main_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !ce);

  reset_cfg_a: assert property (@(posedge clk) $fell(rst) |-> cfg.base == `ICD_BASE_RST
    && cfg.fifo_en && cfg.balanced && cfg.dma_ch3 && !cfg.clk10 && cfg.irq_line == 3'd2)
    else $error("configuration reset value wrong");
  small_window_a: assert property (ce && !cfg.fifo_en && isa_req.addr[9:4] != cfg.base
    ##1 ce |-> !card_sel) else $error("select outside 16-port window");
  base_match_a: assert property (ce && isa_req.addr[9:4] == cfg.base |=> card_sel)
    else $error("base block not selected");
  upper_block_a: assert property (ce && cfg.fifo_en && cfg.base == 6'h30
    && isa_req.addr == 10'h31A |=> card_sel) else $error("upper block not selected");
  irq_gate_a: assert property (isa_irq != 8'h00 |-> $past(firq_en_q) && $past(half))
    else $error("isa interrupt without enable");
  irq_line_a: assert property (isa_irq != 8'h00 |-> isa_irq == 8'h01 << $past(cfg.irq_line))
    else $error("isa interrupt on wrong line");
  fifo_off_a: assert property (!cfg.fifo_en ##1 ce |-> cnt_q == '0)
    else $error("fifo holds data while off");
  push_both_a: assert property (push && !pop ##1 ce |-> result_q == $past(conv_data)
    && cnt_q == $past(cnt_q) + 1'b1) else $error("result not stored twice");
  da_take_a: assert property (wr_edge && off == `ICD_OFF_DA_HI ##1 ce
    |-> da_code == {$past(isa_req.wdata), $past(da_lo_q)}) else $error("output code lost");
  route_a: assert property (##1 ce |-> (ribbon_do[3:0] | main_do) == $past(do_q[3:0])
    && (ribbon_do[3:0] & main_do) == 4'h0) else $error("output routing wrong");
  trig_sel_a: assert property (##1 ce |-> conv_trig == $past(cfg.trig_di2 ? di[2]
    : timer_gate_zero_source)) else $error("trigger source wrong");
  gate_sel_a: assert property (##1 ce |-> ctr0_gate == $past(cfg.gate_di0 ? di[0]
    : gate_pin)) else $error("counter gate source wrong");
  chan_mode_a: assert property (cfg.balanced ##2 ce |-> !adc_chan[3])
    else $error("balanced mode channel out of range");
  pacer_cause_a: assert property (pacer_out |-> $past(tick) && $past(c1_q) == 16'h0000
    && $past(c2_q) == 16'h0000) else $error("pacer pulse without cascade wrap");
  ack_one_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");

  half_full_c: cover property (half_rise);
  fifo_read_c: cover property (pop);
  pacer_c: cover property (pacer_out);
  wb_write_c: cover property (wr_cfg);
endmodule : icd_top

// [verif/icd_host_model.sv]
/*
  Host-side model: ISA processor port cycles and the DMA controller.
  Assumes the card samples strobes on rising clk edges, answers registered.
*/
`timescale 1ns/1ps
module icd_host_model
  import icd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // isa bus
  output icd_isa_req_t req,
  input wire logic [7:0] data,
  input wire logic oe,
  input wire logic sel,
  input wire logic [3:0] drq,
  output logic [3:0] dack
);
  // ------------------------------------------------------------
  // processor cycles
  // ------------------------------------------------------------
  logic [9:0] base = 10'h300;
  int dly = 0;
  int cnt = 0;
  // released data lines show a changed pattern, never the old value
  initial begin
    req = '{addr: 10'h000, rd: 1'b0, wr: 1'b0, wdata: 8'h00};
    dack = 4'h0;
  end
  // write: strobe held over two edges, dropped for a cycle after
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    @(posedge clk);
    req <= '{addr: a, rd: 1'b0, wr: 1'b1, wdata: v};
    repeat (2) @(posedge clk);
    req <= '{addr: a, rd: 1'b0, wr: 1'b0, wdata: ~v};
  endtask : wr
  // read: answer looked at mid-cycle after the taking edge
  task automatic rd(input logic [9:0] a, output logic [7:0] v, output logic hit);
    @(posedge clk);
    req <= '{addr: a, rd: 1'b1, wr: 1'b0, wdata: ~req.wdata};
    @(posedge clk);
    @(negedge clk);
    v = data;
    hit = sel & oe;
    @(posedge clk);
    req <= '{addr: a, rd: 1'b0, wr: 1'b0, wdata: ~req.wdata};
  endtask : rd
  // daughterboard channel code on the four low output bits
  task automatic mux_chan(input logic [3:0] ch);
    wr(base + 10'h003, {4'h0, ch});
  endtask : mux_chan
  // output code is 12 bits wide, so it never leaves 0..4095
  task automatic dac(input logic [11:0] g);
    wr(base + 10'h004, {g[3:0], 4'h0});
    wr(base + 10'h005, g[11:4]);
  endtask : dac
  task automatic firq(input logic en);
    wr(base + 10'h006, {7'h00, en});
  endtask : firq
  // dma controller: acknowledge after dly cycles, prompt or slow
  always @(posedge clk) begin
    if (rst) begin
      dack <= 4'h0;
      cnt <= 0;
    end else if (dack != 4'h0) begin
      dack <= 4'h0;
    end else if (drq != 4'h0 && cnt >= dly) begin
      dack <= drq;
      cnt <= 0;
    end else begin
      cnt <= (drq != 4'h0) ? cnt + 1 : 0;
    end
  end
endmodule : icd_host_model

// [verif/test_icd_top.sv]
/*
  Self-checking bench of the card decode block, one task per scenario.
  Assumes the host model for ISA cycles and a classic Wishbone master here.
*/
`timescale 1ns/1ps
`include "icd_params.svh"
module test_icd_top;
  import icd_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clk, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, cv = 1'b0;
  logic tgz = 1'b0, gpin = 1'b0, ack, irq, oe, sel, trig, gate, pace, h;
  // enable and byte lanes are driven so that freeze and masking get tested
  logic ce = 1'b1;
  logic [3:0] bsel = 4'hF;
  logic [5:0] adr = 6'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [7:0] dout, iirq, d;
  logic [3:0] drq, dack, chan, mdo;
  logic [11:0] cd = 12'h000, da;
  logic [15:0] di = 16'h0000, rdo;
  icd_isa_req_t req;
  icd_cfg_t c;
  int fail_count = 0, n_compared = 0, n;
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  icd_top #(.DEPTH(16)) dut (.clk(clk), .rst(rst), .ce(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(bsel), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .wb_irq_o(irq), .isa_req(req), .isa_data_out(dout),
    .isa_data_oe(oe), .card_sel(sel), .isa_irq(iirq), .isa_drq(drq), .isa_dack(dack),
    .conv_valid(cv), .conv_data(cd), .timer_gate_zero_source(tgz), .gate_pin(gpin),
    .di(di), .adc_chan(chan), .conv_trig(trig), .ctr0_gate(gate), .pacer_out(pace),
    .da_code(da), .ribbon_do(rdo), .main_do(mdo));
  icd_host_model host (.clk(clk), .rst(rst), .req(req), .data(dout), .oe(oe),
    .sel(sel), .drq(drq), .dack(dack));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  // one classic cycle; no answer within 19 edges counts as a mismatch
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] v);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= v;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    chk(32'(k < 20), 32'h1, "bus answer");
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic cfg_set();
    wb(1'b1, `ICD_WB_CFG, {12'h000, c});
  endtask : cfg_set
  task automatic conv(input logic [11:0] v);
    @(posedge clk);
    cv <= 1'b1;
    cd <= v;
    @(posedge clk);
    cv <= 1'b0;
    cd <= ~v;
  endtask : conv
  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : settle
  task automatic probe(input logic [9:0] a, input logic e);
    host.rd(a, d, h);
    chk(32'(h), 32'(e), "card select");
  endtask : probe
  task automatic rdp(input logic [4:0] o, input logic [7:0] e);
    host.rd(host.base + 10'(o), d, h);
    chk(32'({h, d}), 32'({1'b1, e}), "port read");
  endtask : rdp
  task automatic gap();
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (pace !== 1'b1 && n < 4000);
  endtask : gap
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    c = '{dma_en: 1'b0, route_main: 4'h0, irq_line: 3'd2, gate_di0: 1'b0, trig_di2: 1'b0,
      clk10: 1'b0, dma_ch3: 1'b1, balanced: 1'b1, fifo_en: 1'b1, base: 6'h30};
    wb(1'b0, `ICD_WB_CFG, 32'h0);
    chk(q, {12'h000, c}, "config");
    wb(1'b1, 6'h1C, 32'hFFFFFFFF);
    wb(1'b0, 6'h1C, 32'h0);
    chk(q, 32'h0, "unmapped");
    // only the low byte lane may land: base moves, upper fields stay
    bsel <= 4'h1;
    wb(1'b1, `ICD_WB_CFG, 32'hFFFFFFC5);
    bsel <= 4'hF;
    wb(1'b0, `ICD_WB_CFG, 32'h0);
    c.base = 6'h05;
    chk(q, {12'h000, c}, "byte select");
    c.base = 6'h30;
    cfg_set();
  endtask : t_reset
  task automatic t_decode();
    probe(10'h300, 1'b1);
    probe(10'h31F, 1'b1);
    probe(10'h320, 1'b0);
    probe(10'h2FF, 1'b0);
    c.fifo_en = 1'b0;
    cfg_set();
    probe(10'h30F, 1'b1);
    probe(10'h310, 1'b0);
    c.fifo_en = 1'b1;
    c.base = 6'h3F;
    cfg_set();
    probe(10'h3F0, 1'b1);
    c.base = 6'h00;
    cfg_set();
    probe(10'h010, 1'b1);
    probe(10'h020, 1'b0);
    c.base = 6'h05;
    cfg_set();
    probe(10'h050, 1'b1);
    probe(10'h280, 1'b0);
    c.base = 6'h30;
    cfg_set();
  endtask : t_decode
  task automatic t_result();
    conv(12'hABC);
    settle();
    rdp(5'd0, 8'hBC);
    rdp(5'd1, 8'h0A);
    rdp(5'd23, 8'hBC);
    rdp(5'd24, 8'h0A);
    c.fifo_en = 1'b0;
    cfg_set();
    conv(12'h5D3);
    settle();
    rdp(5'd0, 8'hD3);
    probe(10'h317, 1'b0);
    c.fifo_en = 1'b1;
    cfg_set();
  endtask : t_result
  task automatic t_irq();
    host.firq(1'b1);
    repeat (7) conv(12'h123);
    settle();
    chk(32'(iirq), 32'h0, "below half");
    conv(12'h456);
    settle();
    chk(32'(iirq), 32'h04, "half line 2");
    host.firq(1'b0);
    settle();
    chk(32'(iirq), 32'h0, "irq off");
    c.irq_line = 3'd7;
    cfg_set();
    host.firq(1'b1);
    settle();
    chk(32'(iirq), 32'h80, "line 7");
    wb(1'b0, `ICD_WB_STAT, 32'h0);
    chk(32'(q[0]), 32'h1, "status");
    wb(1'b1, `ICD_WB_IEN, 32'h1);
    settle();
    chk(32'(irq), 32'h1, "raised");
    wb(1'b1, `ICD_WB_CLR, 32'h1);
    settle();
    chk(32'(irq), 32'h0, "cleared, others masked");
    wb(1'b1, `ICD_WB_IEN, 32'h0);
    c.irq_line = 3'd2;
  endtask : t_irq
  task automatic t_dma();
    for (int k = 0; k < 2; k++) begin
      c.dma_en = 1'b1;
      c.dma_ch3 = (k == 0);
      cfg_set();
      host.dly = k * 6;
      conv(12'h777);
      @(negedge clk);
      chk(32'(drq), k ? 32'h2 : 32'h8, "request");
      repeat (12) @(posedge clk);
      @(negedge clk);
      chk(32'(drq), 32'h0, "acknowledged");
    end
    c = `ICD_CFG_RST;
    cfg_set();
  endtask : t_dma
  task automatic t_mux();
    for (int s = 0; s < 2; s++) begin
      c.trig_di2 = s[0];
      c.gate_di0 = s[0];
      cfg_set();
      @(posedge clk);
      tgz <= ~s[0];
      gpin <= s[0];
      di <= s ? 16'h0001 : 16'h0004;
      settle();
      chk(32'(trig), s ? 32'(di[2]) : 32'(tgz), "trigger");
      chk(32'(gate), s ? 32'(di[0]) : 32'(gpin), "gate");
    end
    c = `ICD_CFG_RST;
  endtask : t_mux
  task automatic t_pins();
    logic [3:0] rt[3] = '{4'h0, 4'h5, 4'hF};
    logic [11:0] g[3] = '{12'hFA5, 12'hFFF, 12'h000};
    for (int k = 0; k < 3; k++) begin
      c.route_main = rt[k];
      cfg_set();
      host.mux_chan(4'hB);
      host.dac(g[k]);
      settle();
      chk(32'(mdo), 32'(4'hB & rt[k]), "main out");
      chk(32'(rdo[3:0]), 32'(4'hB & ~rt[k]), "ribbon out");
      chk(32'(da), 32'(g[k]), "output code");
    end
    for (int k = 0; k < 2; k++) begin
      c.balanced = k[0];
      cfg_set();
      host.wr(host.base + 10'h002, 8'h0F);
      settle();
      chk(32'(chan), k ? 32'h7 : 32'hF, "channel");
    end
    // a port write while the enable is low must not land
    @(posedge clk);
    ce <= 1'b0;
    host.wr(host.base + 10'h002, 8'h03);
    @(posedge clk);
    ce <= 1'b1;
    settle();
    chk(32'(chan), 32'h7, "frozen channel");
  endtask : t_pins
  task automatic t_pacer();
    for (int k = 0; k < 2; k++) begin
      c = `ICD_CFG_RST;
      c.clk10 = k[0];
      cfg_set();
      wb(1'b1, `ICD_WB_FIRST_PACER_DIVISOR, 32'h2);
      wb(1'b1, `ICD_WB_SECOND_PACER_DIVISOR, 32'h3);
      gap();
      gap();
      gap();
      chk(32'(n), k ? 32'd30 : 32'd300, "pacer period");
    end
  endtask : t_pacer
  // verdict, reached from the main sequence or the watchdog
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test
  // main sequence after four reset cycles
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_decode();
    t_result();
    t_irq();
    t_dma();
    t_mux();
    t_pins();
    t_pacer();
    end_of_test();
  end
  // watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    end_of_test();
  end
endmodule : test_icd_top
